//--- rtl/dus_defines.svh
// Register offsets, control bit positions and dividers of the dual serial port.
// Assumes the CPU special-function bus decodes 8-bit addresses.
`ifndef DUS_DEFINES_SVH
`define DUS_DEFINES_SVH
`define DUS_ADDR_CTRL0 8'h98
`define DUS_ADDR_BUF0 8'h99
`define DUS_ADDR_CTRL1 8'hc0
`define DUS_ADDR_BUF1 8'hc1
`define DUS_CTRL_RESET 8'h00
`define DUS_BIT_MODE_HI 7
`define DUS_BIT_MODE_LO 6
`define DUS_BIT_SHIFT_RATE 5
`define DUS_BIT_RX_EN 4
`define DUS_BIT_TX9 3
`define DUS_BIT_RX9 2
`define DUS_BIT_TX_DONE 1
`define DUS_BIT_RX_DONE 0
`define DUS_M0_DIV_SLOW 4'hc
`define DUS_M0_DIV_FAST 4'h4
`define DUS_M0_LAST_BIT 4'h7
`define DUS_M1_LAST_BIT 4'h9
`define DUS_M23_LAST_BIT 4'ha
`define DUS_OVS_LAST 4'hf
`define DUS_SAMPLE_POINT 4'h7
`define DUS_QUEUE_DEPTH 2'h2
`endif

//--- rtl/dus_pkg.sv
// Types of the dual serial port: modes and the per-port state record.
// Assumes dus_defines.svh supplies the numeric constants.
package dus_pkg;
  // Mode select field read as a binary value
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC8,
    MODE_ASYNC9_OSC,
    MODE_ASYNC9_TIMER
  } dus_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] hold;
    logic [8:0] q0;
    logic [8:0] q1;
    logic [1:0] qn;
    logic tx_act;
    logic [10:0] tx_sh;
    logic [3:0] tx_n;
    logic [3:0] tx_sub;
    logic rx_act;
    logic [9:0] rx_sh;
    logic [3:0] rx_n;
    logic [3:0] rx_sub;
    logic [3:0] div;
    logic half;
    logic rx_prev;
    logic txd;
    logic rdo;
    logic roe_n;
  } dus_port_t;

  typedef struct packed {
    dus_port_t [1:0] p;
    logic [7:0] rdata;
  } dus_state_t;
endpackage

//--- rtl/dus_serial.sv
// Dual serial port: two control/buffer register pairs, shift and async engines.
// Assumes a synchronous special-function bus and timer overflow pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "dus_defines.svh"

module dus_serial (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wr_data,
  input wire logic sfr_rd_en,
  output logic [7:0] sfr_rd_data,
  input wire logic baud_doubler_port0,
  input wire logic baud_doubler_port1,
  input wire logic port0_use_timer2,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic [1:0] rxd_in,
  output logic [1:0] rxd_out,
  output logic [1:0] rxd_oe_n,
  output logic [1:0] txd_out,
  output logic [1:0] tx_buffer_ready
);

  dus_pkg::dus_state_t st;
  dus_pkg::dus_state_t next_st;

  // Returns {hit, port, is_buffer}
  function automatic logic [2:0] dus_decode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      `DUS_ADDR_CTRL0: r = 3'h4;
      `DUS_ADDR_BUF0: r = 3'h5;
      `DUS_ADDR_CTRL1: r = 3'h6;
      `DUS_ADDR_BUF1: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic [2:0] dec;
    logic [1:0] md;
    logic dbl;
    logic t2;
    logic src;
    logic tick;
    logic [3:0] full;
    logic [3:0] half;
    logic [3:0] last;
    logic done;
    dec = dus_decode(sfr_addr);
    md = 2'h0;
    dbl = 1'b0;
    t2 = 1'b0;
    src = 1'b0;
    tick = 1'b0;
    full = 4'h0;
    half = 4'h0;
    last = 4'h0;
    done = 1'b0;
    next_st = st;
    next_st.rdata = 8'h00;
    // Unmapped reads return zero; reads have no side effect
    if (sfr_rd_en && dec[2])
    begin
      next_st.rdata = dec[0] ? st.p[dec[1]].hold : st.p[dec[1]].ctrl;
    end
    // Ports share nothing but the bus and the timer pulses
    for (int i = 0; i < 2; i++)
    begin
      done = 1'b0;
      md = st.p[i].ctrl[`DUS_BIT_MODE_HI:`DUS_BIT_MODE_LO];
      dbl = (i == 0) ? baud_doubler_port0 : baud_doubler_port1;
      full = st.p[i].ctrl[`DUS_BIT_SHIFT_RATE] ? `DUS_M0_DIV_FAST : `DUS_M0_DIV_SLOW;
      half = full >> 1;
      t2 = (i == 0) && port0_use_timer2;
      // Mode 2 prescales the system clock (oscillator over two) by two
      if (md == 2'(dus_pkg::MODE_ASYNC9_OSC))
      begin
        src = 1'b1;
      end
      else
      begin
        src = t2 ? timer2_overflow : timer1_overflow;
      end
      next_st.p[i].half = st.p[i].half ^ src;
      // Sixteen ticks per bit; doubler skips the halving
      tick = src & ((t2 && md != 2'(dus_pkg::MODE_ASYNC9_OSC)) | dbl | st.p[i].half);
      last = (md == 2'(dus_pkg::MODE_ASYNC8)) ? `DUS_M1_LAST_BIT : `DUS_M23_LAST_BIT;
      // Control write; hardware flag sets below win over it
      if (sfr_wr_en && dec == {1'b1, 1'(i), 1'b0})
      begin
        next_st.p[i].ctrl = sfr_wr_data;
        if (sfr_wr_data[`DUS_BIT_MODE_HI:`DUS_BIT_MODE_LO] == 2'(dus_pkg::MODE_SHIFT)
            && sfr_wr_data[`DUS_BIT_RX_EN] && !sfr_wr_data[`DUS_BIT_RX_DONE]
            && !st.p[i].tx_act && !st.p[i].rx_act && st.p[i].qn == 2'h0)
        begin
          next_st.p[i].rx_act = 1'b1;
          next_st.p[i].rx_n = 4'h0;
          next_st.p[i].div = 4'h0;
        end
      end
      // Drain the transmit buffer; shift mode waits for reception
      if (st.p[i].qn != 2'h0 && !st.p[i].tx_act && !(md == 2'h0 && st.p[i].rx_act))
      begin
        next_st.p[i].tx_act = 1'b1;
        next_st.p[i].tx_n = 4'h0;
        next_st.p[i].tx_sub = 4'h0;
        next_st.p[i].div = 4'h0;
        unique case (md)
          2'(dus_pkg::MODE_SHIFT): next_st.p[i].tx_sh = {3'h7, st.p[i].q0[7:0]};
          2'(dus_pkg::MODE_ASYNC8): next_st.p[i].tx_sh = {2'h3, st.p[i].q0[7:0], 1'b0};
          default: next_st.p[i].tx_sh = {1'b1, st.p[i].q0, 1'b0};
        endcase
        next_st.p[i].q0 = st.p[i].q1;
        next_st.p[i].qn = st.p[i].qn - 2'h1;
      end
      // Buffer write; a write to a full buffer is dropped
      if (sfr_wr_en && dec == {1'b1, 1'(i), 1'b1} && st.p[i].qn != `DUS_QUEUE_DEPTH)
      begin
        if (next_st.p[i].qn == 2'h0)
        begin
          next_st.p[i].q0 = {st.p[i].ctrl[`DUS_BIT_TX9], sfr_wr_data};
        end
        else
        begin
          next_st.p[i].q1 = {st.p[i].ctrl[`DUS_BIT_TX9], sfr_wr_data};
        end
        next_st.p[i].qn = next_st.p[i].qn + 2'h1;
      end
      // ************************************************************
      // Shift mode engine
      // ************************************************************
      if (md == 2'(dus_pkg::MODE_SHIFT) && (st.p[i].tx_act || st.p[i].rx_act))
      begin
        next_st.p[i].div = (st.p[i].div == full - 4'h1) ? 4'h0 : st.p[i].div + 4'h1;
        // Sample just before the clock rises, while the slave holds data
        if (st.p[i].rx_act && st.p[i].div == half - 4'h1)
        begin
          next_st.p[i].rx_sh = {rxd_in[i], st.p[i].rx_sh[9:1]};
        end
        if (st.p[i].div == full - 4'h1)
        begin
          if (st.p[i].tx_act)
          begin
            next_st.p[i].tx_sh = {1'b1, st.p[i].tx_sh[10:1]};
            next_st.p[i].tx_n = st.p[i].tx_n + 4'h1;
            if (st.p[i].tx_n == `DUS_M0_LAST_BIT)
            begin
              next_st.p[i].tx_act = 1'b0;
              next_st.p[i].ctrl[`DUS_BIT_TX_DONE] = 1'b1;
            end
          end
          if (st.p[i].rx_act)
          begin
            next_st.p[i].rx_n = st.p[i].rx_n + 4'h1;
            if (st.p[i].rx_n == `DUS_M0_LAST_BIT)
            begin
              next_st.p[i].rx_act = 1'b0;
              done = 1'b1;
            end
          end
        end
      end
      // ************************************************************
      // Async transmit and receive, independent of each other
      // ************************************************************
      if (md != 2'(dus_pkg::MODE_SHIFT) && st.p[i].tx_act && tick)
      begin
        next_st.p[i].tx_sub = st.p[i].tx_sub + 4'h1;
        if (st.p[i].tx_sub == `DUS_OVS_LAST)
        begin
          next_st.p[i].tx_sh = {1'b1, st.p[i].tx_sh[10:1]};
          next_st.p[i].tx_n = st.p[i].tx_n + 4'h1;
          if (st.p[i].tx_n == last)
          begin
            next_st.p[i].tx_act = 1'b0;
            next_st.p[i].ctrl[`DUS_BIT_TX_DONE] = 1'b1;
          end
        end
      end
      next_st.p[i].rx_prev = rxd_in[i];
      if (md != 2'(dus_pkg::MODE_SHIFT) && !st.p[i].rx_act && st.p[i].ctrl[`DUS_BIT_RX_EN]
          && st.p[i].rx_prev && !rxd_in[i])
      begin
        next_st.p[i].rx_act = 1'b1;
        next_st.p[i].rx_sub = 4'h0;
        next_st.p[i].rx_n = 4'h0;
      end
      else if (md != 2'(dus_pkg::MODE_SHIFT) && st.p[i].rx_act && tick)
      begin
        next_st.p[i].rx_sub = st.p[i].rx_sub + 4'h1;
        if (st.p[i].rx_sub == `DUS_SAMPLE_POINT)
        begin
          next_st.p[i].rx_n = st.p[i].rx_n + 4'h1;
          // A start bit gone high by mid-bit was a glitch
          if (st.p[i].rx_n == 4'h0 && rxd_in[i])
          begin
            next_st.p[i].rx_act = 1'b0;
          end
          else if (st.p[i].rx_n != 4'h0)
          begin
            next_st.p[i].rx_sh = {rxd_in[i], st.p[i].rx_sh[9:1]};
            if (st.p[i].rx_n == last)
            begin
              next_st.p[i].rx_act = 1'b0;
              done = 1'b1;
            end
          end
        end
      end
      // Word lost if software has not yet taken the previous one
      if (done && !next_st.p[i].ctrl[`DUS_BIT_RX_DONE])
      begin
        unique case (md)
          2'(dus_pkg::MODE_SHIFT): next_st.p[i].hold = next_st.p[i].rx_sh[9:2];
          2'(dus_pkg::MODE_ASYNC8):
          begin
            next_st.p[i].hold = next_st.p[i].rx_sh[8:1];
            next_st.p[i].ctrl[`DUS_BIT_RX9] = next_st.p[i].rx_sh[9];
          end
          default:
          begin
            next_st.p[i].hold = next_st.p[i].rx_sh[7:0];
            next_st.p[i].ctrl[`DUS_BIT_RX9] = next_st.p[i].rx_sh[8];
          end
        endcase
        next_st.p[i].ctrl[`DUS_BIT_RX_DONE] = 1'b1;
      end
      // Pins follow the next state so they stay in step with it
      if (md == 2'(dus_pkg::MODE_SHIFT))
      begin
        next_st.p[i].txd = !(next_st.p[i].tx_act || next_st.p[i].rx_act)
                           || next_st.p[i].div >= half;
        next_st.p[i].rdo = next_st.p[i].tx_act ? next_st.p[i].tx_sh[0] : 1'b1;
        next_st.p[i].roe_n = !next_st.p[i].tx_act;
      end
      else
      begin
        next_st.p[i].txd = next_st.p[i].tx_act ? next_st.p[i].tx_sh[0] : 1'b1;
        next_st.p[i].rdo = 1'b1;
        next_st.p[i].roe_n = 1'b1;
      end
    end
    if (srst)
    begin
      next_st = '0;
      for (int i = 0; i < 2; i++)
      begin
        next_st.p[i].ctrl = `DUS_CTRL_RESET;
        next_st.p[i].txd = 1'b1;
        next_st.p[i].rdo = 1'b1;
        next_st.p[i].roe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign sfr_rd_data = st.rdata;
  for (genvar g = 0; g < 2; g++)
  begin : g_pins
    assign txd_out[g] = st.p[g].txd;
    assign rxd_out[g] = st.p[g].rdo;
    assign rxd_oe_n[g] = st.p[g].roe_n;
    assign tx_buffer_ready[g] = st.p[g].qn != `DUS_QUEUE_DEPTH;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  chk_m0_div_slow: assert property (
    $fell(txd_out[1]) && st.p[1].ctrl[7:5] == 3'h0 |-> !txd_out[1] [*6] ##1 txd_out[1])
    else $error("port1 shift clock low phase not six cycles");
  chk_m0_div_fast: assert property (
    $fell(txd_out[0]) && st.p[0].ctrl[7:5] == 3'h1 |-> !txd_out[0] [*2] ##1 txd_out[0] [*2])
    else $error("port0 fast shift clock phases not two cycles");
  chk_buf_read_route: assert property (
    sfr_rd_en && sfr_addr == `DUS_ADDR_BUF0 |=> sfr_rd_data == $past(st.p[0].hold))
    else $error("buffer read did not return receive holding");
  chk_write_starts_tx: assert property (
    sfr_wr_en && sfr_addr == `DUS_ADDR_BUF1 && st.p[1].qn == 2'h0 && !st.p[1].tx_act
    |-> ##[1:2] st.p[1].tx_act)
    else $error("buffer write did not start transmission");
  chk_m0_rx_start: assert property (
    sfr_wr_en && sfr_addr == `DUS_ADDR_CTRL0 && sfr_wr_data[7:6] == 2'h0
    && sfr_wr_data[4] && !sfr_wr_data[0] && !st.p[0].tx_act && !st.p[0].rx_act
    && st.p[0].qn == 2'h0 |=> st.p[0].rx_act ##1 !txd_out[0])
    else $error("shift mode reception did not start");
  chk_async_pin_released: assert property (
    st.p[0].ctrl[7:6] != 2'h0 |=> rxd_oe_n[0])
    else $error("data pin driven outside shift mode");
  chk_frame_len_m1: assert property (
    st.p[0].ctrl[7:6] == 2'h1 && st.p[0].tx_act |-> st.p[0].tx_n <= 4'h9)
    else $error("mode 1 frame longer than ten bits");
  chk_ninth_tx_load: assert property (
    $rose(st.p[0].tx_act) && st.p[0].ctrl[7] |-> st.p[0].tx_sh[9] == $past(st.p[0].q0[8]))
    else $error("ninth transmit bit not loaded");
  chk_tx_flag_set: assert property (
    st.p[1].tx_act ##1 !st.p[1].tx_act |-> st.p[1].ctrl[1])
    else $error("transmit done flag not set at frame end");
  chk_port1_timer1: assert property (
    st.p[1].ctrl[6] && st.p[1].rx_act && !timer1_overflow |=> $stable(st.p[1].rx_sub))
    else $error("port1 timed from a source other than timer 1");

endmodule // dus_serial
`default_nettype wire

//--- testbench/dus_far_model.sv
// Far-side model: mode 0 slave peripheral and remote async UART per port.
// Assumes the bench calls its tasks; pins sampled on the same mclk.
`timescale 1ns/1ps
`default_nettype none

module dus_far_model (
  input wire logic mclk,
  input wire logic [1:0] txd_out,
  input wire logic [1:0] rxd_out,
  input wire logic [1:0] rxd_oe_n,
  output logic [1:0] rxd_in
);
  logic [1:0] line = 2'h3;
  logic [1:0] m0_on = 2'h0;
  logic [7:0] sh0 = 8'h00;
  logic [7:0] sh1 = 8'h00;

  // Pulled-up data line; the device wins while it drives
  assign rxd_in[0] = !rxd_oe_n[0] ? rxd_out[0] : (m0_on[0] ? sh0[0] : line[0]);
  assign rxd_in[1] = !rxd_oe_n[1] ? rxd_out[1] : (m0_on[1] ? sh1[0] : line[1]);

  // Slave shifts only on the device clock, after each rise
  always @(posedge txd_out[0]) if (m0_on[0]) sh0 <= sh0 >> 1;
  always @(posedge txd_out[1]) if (m0_on[1]) sh1 <= sh1 >> 1;

  task automatic snd(input int p, input int bl, input int nb, input logic [10:0] v);
    for (int k = 0; k < nb; k++)
    begin
      line[p] <= v[k];
      repeat (bl) @(posedge mclk);
    end
    line[p] <= 1'b1;
  endtask

  task automatic cap(input int p, input int bl, input int nb, output logic [10:0] v);
    int n;
    v = 11'h000;
    n = 0;
    while (txd_out[p] !== 1'b0 && n < 5000)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (bl / 2) @(posedge mclk);
    for (int k = 0; k < nb; k++)
    begin
      v[k] = txd_out[p];
      // End at the stop bit's close so a queued frame's start is not missed
      repeat ((k + 1 < nb) ? bl : bl / 2) @(posedge mclk);
    end
  endtask

  task automatic cap0(input int p, output logic [7:0] v, output int per);
    realtime t0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge txd_out[p]);
      if (k == 0) t0 = $realtime;
      if (k == 1) per = int'(($realtime - t0) / 100.0);
      v[k] = rxd_out[p];
    end
  endtask
endmodule // dus_far_model
`default_nettype wire

//--- testbench/test_dual_uart_serial_port.sv
// Bench for the dual serial port: register tasks and far-side traffic.
// Assumes a 10 MHz mclk and timer overflows every second cycle.
`timescale 1ns/1ps
`default_nettype none

module test_dual_uart_serial_port;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr_en = 1'b0;
  logic [7:0] sfr_wr_data = 8'h00;
  logic sfr_rd_en = 1'b0;
  logic [7:0] sfr_rd_data;
  logic dbl0 = 1'b0;
  logic dbl1 = 1'b0;
  logic use_t2 = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [1:0] rxd_in, rxd_out, rxd_oe_n, txd_out, tx_buffer_ready;
  logic [10:0] v0, v1;
  logic [7:0] d, b;
  int per, checks = 0, fail_count = 0;

  always #50 mclk = ~mclk;
  always @(posedge mclk) t1 <= ~t1;
  always @(posedge mclk) t2 <= ~t2;

  dus_serial dut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data),
    .baud_doubler_port0(dbl0), .baud_doubler_port1(dbl1), .port0_use_timer2(use_t2),
    .timer1_overflow(t1), .timer2_overflow(t2), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd_out(txd_out), .tx_buffer_ready(tx_buffer_ready));
  dus_far_model far (.mclk(mclk), .txd_out(txd_out), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .rxd_in(rxd_in));

  // ***************
  // Tasks
  // ***************
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wr_data <= dt;
    sfr_wr_en <= 1'b1;
    @(posedge mclk);
    sfr_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge mclk);
    sfr_rd_en <= 1'b0;
    #1 dt = sfr_rd_data;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    chk({3'h0, r}, {3'h0, exp});
  endtask

  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    wrap_up;
  end

  // ***************
  // Tests
  // ***************
  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rdchk(8'h98, 8'h00);
    rdchk(8'hc0, 8'h00);
    wr(8'h55, 8'hff);
    rdchk(8'h55, 8'h00);
    wr(8'hc0, 8'hb8);
    rdchk(8'hc0, 8'hb8);
    // Mode 0 transmit: port 0 fast, port 1 slow
    for (int p = 0; p < 2; p++)
    begin
      b = (p == 0) ? 8'h20 : 8'h00;
      wr(p ? 8'hc0 : 8'h98, b);
      fork
        far.cap0(p, d, per);
        wr(p ? 8'hc1 : 8'h99, 8'h3c ^ p[7:0]);
      join
      chk({3'h0, d}, {3'h0, 8'h3c ^ p[7:0]});
      chk(11'(per), p ? 11'd12 : 11'd4);
      repeat (24) @(posedge mclk);
      rdchk(p ? 8'hc0 : 8'h98, b | 8'h02);
    end
    // Mode 0 reception by the device clock
    far.sh0 = 8'h96;
    far.m0_on[0] = 1'b1;
    wr(8'h98, 8'h30);
    d = 8'h00;
    for (int n = 0; n < 60 && !d[0]; n++) rd(8'h98, d);
    far.m0_on[0] = 1'b0;
    chk({3'h0, d}, 11'h031);
    rdchk(8'h99, 8'h96);
    // Mode 2 transmit, port 0 doubled: ninth bit from control
    dbl0 <= 1'b1;
    wr(8'h98, 8'h88);
    fork
      far.cap(0, 16, 11, v0);
      wr(8'h99, 8'ha5);
    join
    chk(v0, {2'b11, 8'ha5, 1'b0});
    repeat (16) @(posedge mclk);
    rdchk(8'h98, 8'h8a);
    // Mode 1 on both ports from timer 1, doublers differ
    dbl0 <= 1'b0;
    dbl1 <= 1'b1;
    wr(8'h98, 8'h40);
    wr(8'hc0, 8'h40);
    fork
      far.cap(0, 64, 10, v0);
      far.cap(1, 32, 10, v1);
      begin
        wr(8'h99, 8'h5a);
        wr(8'hc1, 8'hc3);
      end
    join
    chk(v0, {2'b01, 8'h5a, 1'b0});
    chk(v1, {2'b01, 8'hc3, 1'b0});
    // Receive: port 0 mode 3 on timer 2, port 1 mode 1 on timer 1
    use_t2 <= 1'b1;
    wr(8'h98, 8'hd0);
    wr(8'hc0, 8'h50);
    fork
      far.snd(0, 32, 11, {2'b11, 8'h69, 1'b0});
      far.snd(1, 32, 10, {2'b01, 8'h3e, 1'b0});
    join
    rdchk(8'h98, 8'hd5);
    rdchk(8'h99, 8'h69);
    rdchk(8'hc0, 8'h55);
    rdchk(8'hc1, 8'h3e);
    // Transmit buffer: fill to full, then drain three frames
    wr(8'hc0, 8'h80);
    fork
      for (int k = 1; k < 4; k++)
      begin
        far.cap(1, 16, 11, v1);
        chk(v1, {2'b10, 4'(k), 4'(k), 1'b0});
      end
      begin
        wr(8'hc1, 8'h11);
        wr(8'hc1, 8'h22);
        wr(8'hc1, 8'h33);
        #1 chk({10'h0, tx_buffer_ready[1]}, 11'h000);
      end
    join
    repeat (200) @(posedge mclk);
    chk({10'h0, tx_buffer_ready[1]}, 11'h001);
    wrap_up;
  end
endmodule // test_dual_uart_serial_port
`default_nettype wire
